// file: rtl/tsec_top.sv
// Purpose: Timer slice event input conditioner with AHB-Lite registers.
// Assumes: Trigger inputs are asynchronous; one clock core_clk at 125 MHz.
// Notes: Three conditioned events feed a small function routing matrix.
// Notes on behaviour
// - Event 0 source: four-bit select of sixteen.
// - Events 1 and 2 have own selectors.
// - Event 0 edge: none, rise, fall, both.
// - Events 1 and 2 same edge coding.
// - Level bit zero active high, one low.
// - Events 1 and 2 own polarity bits.
// - Filter needs 3, 5 or 7 stable cycles.
// - Events 1 and 2 own filter settings.
// - Unused configuration bits read as zero.
// - Function selectors: off, event 0, 1, 2.
`timescale 1ns/10ps
`default_nettype none
module tsec_top import tsec_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Trigger inputs, asynchronous
  input wire logic [N_INPUTS-1:0] trig_in,
  // Conditioned events
  output logic [N_EVENTS-1:0] event_edge,
  output logic [N_EVENTS-1:0] event_level,
  // Slice functions
  output logic fn_start,
  output logic fn_stop,
  output logic fn_capture0,
  output logic fn_capture1,
  output logic fn_gate,
  output logic fn_updown,
  output logic fn_load,
  output logic fn_count
);

  // ***********************************************************
  // Input synchroniser
  // ***********************************************************
  // Two flops settle the asynchronous triggers before any logic reads them.
  logic [N_INPUTS-1:0] sync1_q, sync2_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= trig_in;
      sync2_q <= sync1_q;
    end
  end

  // ***********************************************************
  // Register bus, address and data phase
  // ***********************************************************
  logic take;
  logic do_write;
  logic wr_pend_q, wr_pend_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;

  always_comb begin
    take = hsel & hready & htrans[1];
    // Narrow writes are dropped, since every register is one whole word.
    do_write = take & hwrite & (hsize == HSIZE_WORD);
    wr_pend_d = do_write;
    wr_addr_d = do_write ? haddr : wr_addr_q;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // ***********************************************************
  // Configuration and routing registers
  // ***********************************************************
  logic [31:0] cfg_q, cfg_d;
  logic [31:0] mat_q, mat_d;

  always_comb begin
    cfg_d = cfg_q;
    mat_d = mat_q;
    if (wr_pend_q && wr_addr_q == OFS_CFG) begin
      cfg_d = hwdata & CFG_RW_MASK;
    end
    if (wr_pend_q && wr_addr_q == OFS_MATRIX) begin
      mat_d = hwdata & MATRIX_RW_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
      mat_q <= MATRIX_RESET;
    end else begin
      cfg_q <= cfg_d;
      mat_q <= mat_d;
    end
  end

  // ***********************************************************
  // Read data
  // ***********************************************************
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status;
  logic [N_EVENTS-1:0] ev_filt;
  logic [N_EVENTS-1:0] ev_act;
  logic [N_EVENTS-1:0] ev_pulse;

  always_comb begin
    // Status shows the filtered pin value and the qualified level of each event.
    status = '0;
    status[STS_FILT_LSB +: N_EVENTS] = ev_filt;
    status[STS_ACT_LSB +: N_EVENTS] = ev_act;
    // A read right behind a write sees the value being written.
    rdata_d = rdata_q;
    if (take && !hwrite) begin
      unique case (haddr)
        OFS_CFG: rdata_d = cfg_d;
        OFS_MATRIX: rdata_d = mat_d;
        OFS_STATUS: rdata_d = status;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // The slave never stretches a transfer and never signals an error.
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = rdata_q;

  // ***********************************************************
  // Event channels
  // ***********************************************************
  // Every event chooses from the same synchronised trigger set.
  for (genvar i = 0; i < N_EVENTS; i++) begin : g_event
    tsec_event_channel u_channel (
      .core_clk(core_clk),
      .rst(rst),
      .trig_in(sync2_q),
      .source_select(cfg_q[SRC_LSB + SRC_STEP * i +: SEL_W]),
      .edge_setting(cfg_q[EDGE_LSB + EDGE_STEP * i +: 2]),
      .level_polarity(cfg_q[POL_LSB + i]),
      .filter_length(cfg_q[FLT_LSB + FLT_STEP * i +: 2]),
      .filtered(ev_filt[i]),
      .level_active(ev_act[i]),
      .edge_pulse(ev_pulse[i])
    );
  end

  assign event_edge = ev_pulse;
  assign event_level = ev_act;

  // ***********************************************************
  // Function routing
  // ***********************************************************
  function automatic logic fn_pick(input logic [1:0] sel, input logic [N_EVENTS-1:0] vec);
    logic pick;
    pick = 1'b0;
    if (sel != FN_OFF) begin
      pick = vec[sel - 2'h1];
    end
    return pick;
  endfunction

  // Edge functions follow the pulses; gate and direction follow the levels.
  // Registering the routed functions keeps them free of glitches.
  logic [7:0] fn_q, fn_d;

  always_comb begin
    fn_d[0] = fn_pick(mat_q[FN_START_LSB +: 2], ev_pulse);
    fn_d[1] = fn_pick(mat_q[FN_STOP_LSB +: 2], ev_pulse);
    fn_d[2] = fn_pick(mat_q[FN_CAP0_LSB +: 2], ev_pulse);
    fn_d[3] = fn_pick(mat_q[FN_CAP1_LSB +: 2], ev_pulse);
    fn_d[4] = fn_pick(mat_q[FN_GATE_LSB +: 2], ev_act);
    fn_d[5] = fn_pick(mat_q[FN_UPDOWN_LSB +: 2], ev_act);
    fn_d[6] = fn_pick(mat_q[FN_LOAD_LSB +: 2], ev_pulse);
    fn_d[7] = fn_pick(mat_q[FN_COUNT_LSB +: 2], ev_pulse);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fn_q <= '0;
    end else begin
      fn_q <= fn_d;
    end
  end

  assign fn_start = fn_q[0];
  assign fn_stop = fn_q[1];
  assign fn_capture0 = fn_q[2];
  assign fn_capture1 = fn_q[3];
  assign fn_gate = fn_q[4];
  assign fn_updown = fn_q[5];
  assign fn_load = fn_q[6];
  assign fn_count = fn_q[7];

endmodule // tsec_top
`default_nettype wire

// file: include/tsec_pkg.sv
// Purpose: Shared constants for the timer slice event input conditioner.
// Assumes: 32-bit AHB-Lite register access, one clock domain.
// Notes: Field positions, offsets and codes are named once here.
package tsec_pkg;

  // ***********************************************************
  // Sizes
  // ***********************************************************
  localparam int unsigned N_EVENTS = 3;
  localparam int unsigned N_INPUTS = 16;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CNT_W = 3;

  // ***********************************************************
  // Register map
  // ***********************************************************
  localparam logic [ADDR_W-1:0] OFS_CFG = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_MATRIX = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [31:0] CFG_RW_MASK = 32'h7fff0fff;
  localparam logic [31:0] MATRIX_RESET = 32'h00000000;
  localparam logic [31:0] MATRIX_RW_MASK = 32'h0000ffff;

  // ***********************************************************
  // Configuration fields, per event the lsb plus event * step
  // ***********************************************************
  localparam int unsigned SRC_LSB = 0;
  localparam int unsigned SRC_STEP = 4;
  localparam int unsigned EDGE_LSB = 16;
  localparam int unsigned EDGE_STEP = 2;
  localparam int unsigned POL_LSB = 22;
  localparam int unsigned FLT_LSB = 25;
  localparam int unsigned FLT_STEP = 2;

  // ***********************************************************
  // Codes
  // ***********************************************************
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] FLT_OFF = 2'h0;
  localparam logic [1:0] FLT_SHORT = 2'h1;
  localparam logic [1:0] FLT_MID = 2'h2;
  localparam logic [1:0] FLT_LONG = 2'h3;
  localparam logic [CNT_W-1:0] FLT_SHORT_CYCLES = 3'h3;
  localparam logic [CNT_W-1:0] FLT_MID_CYCLES = 3'h5;
  localparam logic [CNT_W-1:0] FLT_LONG_CYCLES = 3'h7;
  localparam logic [1:0] FN_OFF = 2'h0;

  // ***********************************************************
  // Connection matrix fields
  // ***********************************************************
  localparam int unsigned FN_START_LSB = 0;
  localparam int unsigned FN_STOP_LSB = 2;
  localparam int unsigned FN_CAP0_LSB = 4;
  localparam int unsigned FN_CAP1_LSB = 6;
  localparam int unsigned FN_GATE_LSB = 8;
  localparam int unsigned FN_UPDOWN_LSB = 10;
  localparam int unsigned FN_LOAD_LSB = 12;
  localparam int unsigned FN_COUNT_LSB = 14;

  // ***********************************************************
  // Status fields
  // ***********************************************************
  localparam int unsigned STS_FILT_LSB = 0;
  localparam int unsigned STS_ACT_LSB = 4;

  // ***********************************************************
  // Bus codes
  // ***********************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// file: rtl/tsec_event_channel.sv
// Purpose: One event path: source pick, low-pass filter, edge and level.
// Assumes: trig_in is already synchronised to core_clk.
// Notes: Instantiated once per event by the top.
`timescale 1ns/10ps
`default_nettype none
module tsec_event_channel import tsec_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Inputs and settings
  input wire logic [N_INPUTS-1:0] trig_in,
  input wire logic [SEL_W-1:0] source_select,
  input wire logic [1:0] edge_setting,
  input wire logic level_polarity,
  input wire logic [1:0] filter_length,
  // Conditioned event
  output logic filtered,
  output logic level_active,
  output logic edge_pulse
);

  logic sample;
  logic [CNT_W-1:0] need;
  logic rise;
  logic fall;
  logic filt_q, filt_d;
  logic prev_q, prev_d;
  logic lvl_q, lvl_d;
  logic pulse_q, pulse_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  always_comb begin
    sample = trig_in[source_select];
    unique case (filter_length)
      FLT_OFF: need = FLT_SHORT_CYCLES;
      FLT_SHORT: need = FLT_SHORT_CYCLES;
      FLT_MID: need = FLT_MID_CYCLES;
      FLT_LONG: need = FLT_LONG_CYCLES;
    endcase
    filt_d = filt_q;
    cnt_d = '0;
    if (filter_length == FLT_OFF) begin
      filt_d = sample;
    end else if (sample != filt_q) begin
      // A return to the accepted value clears the count.
      // A shortened length takes effect at once, even in mid-count.
      if (cnt_q >= CNT_W'(need - 1'b1)) begin
        filt_d = sample;
      end else begin
        cnt_d = CNT_W'(cnt_q + 1'b1);
      end
    end
    prev_d = filt_q;
    rise = filt_q & ~prev_q;
    fall = ~filt_q & prev_q;
    unique case (edge_setting)
      EDGE_NONE: pulse_d = 1'b0;
      EDGE_RISE: pulse_d = rise;
      EDGE_FALL: pulse_d = fall;
      EDGE_BOTH: pulse_d = rise | fall;
    endcase
    lvl_d = filt_q ^ level_polarity;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      filt_q <= 1'b0;
      prev_q <= 1'b0;
      lvl_q <= 1'b0;
      pulse_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      filt_q <= filt_d;
      prev_q <= prev_d;
      lvl_q <= lvl_d;
      pulse_q <= pulse_d;
      cnt_q <= cnt_d;
    end
  end

  assign filtered = filt_q;
  assign level_active = lvl_q;
  assign edge_pulse = pulse_q;

endmodule // tsec_event_channel
`default_nettype wire

// file: sim/tsec_trig_model.sv
// Purpose: Trigger sources seen by the conditioner.
// Assumes: The bench states the wanted levels at clock edges.
// Notes: Levels land off the edge, like asynchronous sources.
`timescale 1ns/10ps
`default_nettype none
module tsec_trig_model import tsec_pkg::*; (
  // Clock
  input wire logic core_clk,
  // Wanted and driven levels
  input wire logic [N_INPUTS-1:0] want,
  output logic [N_INPUTS-1:0] trig_in
);
  initial trig_in = 16'h0000;
  always @(posedge core_clk) trig_in <= #3 want;
endmodule // tsec_trig_model
`default_nettype wire

// file: sim/tsec_top_assertions.sv
// Purpose: Timing checks on the conditioner top ports.
// Assumes: hready is tied to hreadyout.
// Notes: Bound to every tsec_top.
`timescale 1ns/10ps
`default_nettype none
module tsec_top_assertions import tsec_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Events
  input wire logic [N_EVENTS-1:0] event_edge,
  input wire logic [N_EVENTS-1:0] event_level,
  input wire logic fn_start,
  input wire logic fn_count,
  input wire logic fn_gate
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_e0; event_edge[0] |-> event_level[0] != $past(event_level[0]); endproperty
  a_e0: assert property (p_e0) else $error("edge 0 without change");
  property p_e1; event_edge[1] |-> !$stable(event_level[1]); endproperty
  a_e1: assert property (p_e1) else $error("edge 1 without change");
  property p_e2; event_edge[2] |-> $changed(event_level[2]); endproperty
  a_e2: assert property (p_e2) else $error("edge 2 without change");
  property p_st; event_edge == 3'h0 |=> !fn_start; endproperty
  a_st: assert property (p_st) else $error("start without edge");
  property p_cn; fn_count |-> $past(|event_edge); endproperty
  a_cn: assert property (p_cn) else $error("count without edge");
  property p_gt; event_level == 3'h0 ##1 event_level == 3'h0 |=> !fn_gate; endproperty
  a_gt: assert property (p_gt) else $error("gate without level");
  property p_cz; hsel && hready && htrans[1] && !hwrite && haddr == OFS_CFG
    |=> hrdata[15:12] == 4'h0 && !hrdata[31]; endproperty
  a_cz: assert property (p_cz) else $error("reserved bits set");
  property p_mz; hsel && hready && htrans[1] && !hwrite && haddr == OFS_MATRIX
    |=> hrdata[31:16] == 16'h0; endproperty
  a_mz: assert property (p_mz) else $error("matrix upper bits set");
  c_e0: cover property (event_edge[0]);
  c_st: cover property (fn_start);
  c_gt: cover property (fn_gate);
endmodule // tsec_top_assertions
bind tsec_top tsec_top_assertions u_chk (.core_clk(core_clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .event_edge(event_edge), .event_level(event_level), .fn_start(fn_start),
  .fn_count(fn_count), .fn_gate(fn_gate));
`default_nettype wire

// file: sim/tsec_top_tb.sv
// Purpose: Self-checking bench for the event conditioner.
// Assumes: Zero-wait slave, hready tied to hreadyout.
// Notes: One task per scenario.
`timescale 1ns/10ps
`default_nettype none
module tsec_top_tb import tsec_pkg::*; ;
  logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic hreadyout, fn_start, fn_count, fn_gate;
  logic hresp, fn_stop, fn_capture0, fn_capture1, fn_updown, fn_load;
  logic [7:0] fnv;
  int fc [8];
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [ADDR_W-1:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [N_INPUTS-1:0] want = 16'h0000, trig_in;
  logic [N_EVENTS-1:0] event_edge, event_level, seen = 3'h0;
  int mismatches = 0, tests_run = 0, ns = 0, nc = 0, cyc = 0;
  wire hready;
  assign hready = hreadyout;
  tsec_trig_model u_src (.core_clk(core_clk), .want(want), .trig_in(trig_in));
  tsec_top dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .trig_in(trig_in), .event_edge(event_edge),
    .event_level(event_level), .fn_start(fn_start), .fn_stop(fn_stop),
    .fn_capture0(fn_capture0), .fn_capture1(fn_capture1), .fn_gate(fn_gate),
    .fn_updown(fn_updown), .fn_load(fn_load), .fn_count(fn_count));
  assign fnv = {fn_count, fn_load, fn_updown, fn_gate, fn_capture1, fn_capture0,
    fn_stop, fn_start};
  always #4 core_clk = ~core_clk;
  always @(negedge core_clk) seen = seen | event_level;
  always @(posedge core_clk) begin
    cyc++;
    if (fn_start === 1'b1) ns++;
    if (fn_count === 1'b1) nc++;
    for (int k = 0; k < 8; k++) begin
      if (fnv[k] === 1'b1) fc[k]++;
    end
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task ahb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task t_regs();
    logic [31:0] rd;
    ahb(1'b0, OFS_CFG, 32'h0, rd);
    chk("cfg reset", CFG_RESET, rd);
    chk("response", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    ahb(1'b1, OFS_CFG, 32'hffffffff, rd);
    ahb(1'b0, OFS_CFG, 32'h0, rd);
    chk("cfg bits", CFG_RW_MASK, rd);
    ahb(1'b1, OFS_MATRIX, 32'hffffffff, rd);
    ahb(1'b0, OFS_MATRIX, 32'h0, rd);
    chk("matrix bits", MATRIX_RW_MASK, rd);
    ahb(1'b0, 12'h00c, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, OFS_MATRIX, 32'h0, rd);
    ahb(1'b1, OFS_CFG, 32'h0, rd);
    $display("regs done");
  endtask
  task t_source();
    logic [31:0] rd;
    for (int c = 0; c < 16; c++) begin
      ahb(1'b1, OFS_CFG, 32'(c) | 32'((c + 1) % 16) << 4 | 32'((c + 2) % 16) << 8
        | 32'(c % 8) << POL_LSB, rd);
      want <= 16'h0001 << c;
      repeat (12) @(posedge core_clk);
      chk("source levels", 32'h1 ^ 32'(c % 8), {29'h0, event_level});
      ahb(1'b0, OFS_STATUS, 32'h0, rd);
      chk("status", 32'h1 << STS_FILT_LSB | (32'h1 ^ 32'(c % 8)) << STS_ACT_LSB,
        rd);
      want <= 16'h0000;
    end
    $display("source done");
  endtask
  task t_edge();
    logic [31:0] rd;
    int s0, c0;
    ahb(1'b1, OFS_MATRIX, 32'h00008301, rd);
    for (int e = 0; e < 4; e++) begin
      ahb(1'b1, OFS_CFG, 32'(e) << 16 | 32'(e) << 18, rd);
      s0 = ns;
      c0 = nc;
      want <= 16'h0001;
      repeat (12) @(posedge core_clk);
      chk("rise start", 32'(e % 2), 32'(ns - s0));
      chk("gate high", 32'h1, {31'h0, fn_gate});
      want <= 16'h0000;
      repeat (12) @(posedge core_clk);
      chk("both start", 32'(e % 2 + e / 2), 32'(ns - s0));
      chk("both count", 32'(e % 2 + e / 2), 32'(nc - c0));
      chk("gate low", 32'h0, {31'h0, fn_gate});
    end
    $display("edge done");
  endtask
  task t_filter();
    logic [31:0] rd;
    for (int f = 1; f < 4; f++) begin
      ahb(1'b1, OFS_CFG, 32'(f) << 25 | 32'(f) << 27 | 32'(f) << 29, rd);
      seen = 3'h0;
      want <= 16'h0001;
      repeat (2 * f) @(posedge core_clk);
      want <= 16'h0000;
      @(posedge core_clk);
      want <= 16'h0001;
      repeat (2 * f) @(posedge core_clk);
      want <= 16'h0000;
      repeat (14) @(posedge core_clk);
      chk("glitch dropped", 32'h0, {29'h0, seen});
      want <= 16'h0001;
      repeat (2 * f + 1) @(posedge core_clk);
      want <= 16'h0000;
      repeat (14) @(posedge core_clk);
      chk("pulse passed", 32'h7, {29'h0, seen});
    end
    $display("filter done");
  endtask
  task t_route();
    logic [31:0] rd;
    int c0 [8];
    for (int m = 0; m < 2; m++) begin
      ahb(1'b1, OFS_MATRIX, m == 0 ? 32'h00005555 : 32'h0, rd);
      ahb(1'b1, OFS_CFG, 32'(EDGE_BOTH) << EDGE_LSB, rd);
      c0 = fc;
      want <= 16'h0001;
      repeat (12) @(posedge core_clk);
      chk("gate on", 32'(m == 0), {31'h0, fn_gate});
      chk("updown on", 32'(m == 0), {31'h0, fn_updown});
      want <= 16'h0000;
      repeat (12) @(posedge core_clk);
      for (int k = 0; k < 8; k++) begin
        if (k != 4 && k != 5) begin
          chk("function pulses", 32'(2 - 2 * m), 32'(fc[k] - c0[k]));
        end
      end
    end
    $display("route done");
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_source();
    t_edge();
    t_filter();
    t_route();
    complete_run();
  end
endmodule // tsec_top_tb
`default_nettype wire
